// ---- src/dbgtc_top.sv ----
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`include "dbgtc_params.svh"

module dbgtc_top
  import dbgtc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // chip state
  input  wire logic        secure_i,
  // watched cpu bus and comparator values
  input  wire dbgtc_cpu_t  cpu_i,
  input  wire logic [15:0] cmp_a_i,
  input  wire logic [15:0] cmp_b_i,
  // trace buffer
  input  wire logic        fifo_full_i,
  output logic             trace_store_o,
  output logic             event_store_o,
  output logic             run_start_o,
  // core and status
  output dbgtc_brk_t       brk_o,
  output logic             run_active_o
);

  //////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0]   ctrl;
  logic [7:0]   trig;
  dbgtc_state_t state;
  logic         seen_a;
  logic         ack;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;
  logic wr_en;
  logic wr_ctrl;
  logic wr_trig;
  logic next_en;

  // a write lands on the edge that raises ack
  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_en   = req && wb_we_i && !ack && wb_sel_i[0];
  assign wr_ctrl = wr_en && (wb_adr_i == `DBGTC_OFS_CTRL);
  assign wr_trig = wr_en && (wb_adr_i == `DBGTC_OFS_TRIG);

  // the enable refuses to come on in the secured state
  assign next_en = wb_dat_i[`DBGTC_CTRL_EN] && !secure_i;

  //////////////////////////////////////////////////////////////////////////////
  // field views

  logic       en;
  logic       arm;
  logic       brk_en;
  logic       tag_sel;
  logic       opq;
  logic       begin_sel;
  logic [3:0] mode;
  logic       ev_mode;
  logic       begin_eff;

  assign en        = ctrl[`DBGTC_CTRL_EN];
  assign arm       = ctrl[`DBGTC_CTRL_ARM];
  assign brk_en    = ctrl[`DBGTC_CTRL_BRK];
  assign tag_sel   = ctrl[`DBGTC_CTRL_TAG];
  assign opq       = trig[`DBGTC_TRIG_OPQ];
  assign begin_sel = trig[`DBGTC_TRIG_BEGIN];
  assign mode      = trig[3:0];

  // event-only modes always behave as begin trace
  assign ev_mode   = (mode == `DBGTC_M_EVB) || (mode == `DBGTC_M_AEVB);
  assign begin_eff = begin_sel || ev_mode;

  //////////////////////////////////////////////////////////////////////////////
  // comparators with direction qualification

  logic dir_ok_a;
  logic dir_ok_b;
  logic hit_a;
  logic hit_b;
  logic data_eq;
  logic in_rng;
  logic out_rng;

  // direction only matters when its qualify bit is set
  assign dir_ok_a = !ctrl[`DBGTC_CTRL_CMP_A_DIR_QUALIFY]
                    || (cpu_i.rw == ctrl[`DBGTC_CTRL_RWA]);
  assign dir_ok_b = !ctrl[`DBGTC_CTRL_CMP_B_DIR_QUALIFY]
                    || (cpu_i.rw == ctrl[`DBGTC_CTRL_RWB]);

  // address and data matches of this bus cycle
  assign hit_a   = cpu_i.valid && dir_ok_a && (cpu_i.addr == cmp_a_i);
  assign hit_b   = cpu_i.valid && dir_ok_b && (cpu_i.addr == cmp_b_i);
  assign data_eq = cpu_i.data == cmp_b_i[7:0];
  assign in_rng  = cpu_i.valid && dir_ok_a
                   && (cpu_i.addr >= cmp_a_i) && (cpu_i.addr <= cmp_b_i);
  assign out_rng = cpu_i.valid && dir_ok_a
                   && ((cpu_i.addr < cmp_a_i) || (cpu_i.addr > cmp_b_i));

  //////////////////////////////////////////////////////////////////////////////
  // mode decode

  logic [1:0] cond;
  logic [1:0] evt;

  // cond[0] is the first stage, cond[1] the comparator B stage
  always_comb
  begin
    cond = 2'b00;
    unique case (mode)
      `DBGTC_M_A:      cond[0] = hit_a;
      `DBGTC_M_AORB:   cond[0] = hit_a || hit_b;
      `DBGTC_M_ATHENB:
      begin
        cond[0] = hit_a;
        cond[1] = hit_b;
      end
      `DBGTC_M_EVB:    cond[1] = hit_b;
      `DBGTC_M_AEVB:
      begin
        cond[0] = hit_a;
        cond[1] = hit_b;
      end
      `DBGTC_M_ADATB:  cond[0] = hit_a && data_eq;
      `DBGTC_M_ANDATB: cond[0] = hit_a && !data_eq;
      `DBGTC_M_IN:     cond[0] = in_rng;
      `DBGTC_M_OUT:    cond[0] = out_rng;
      default:         cond = 2'b00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // opcode qualification, one per stage

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_qual
      dbgtc_qual u_qual (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .qual_en_i (opq),
        .clear_i   (!run_active_o),
        .cond_i    (cond[i]),
        .fetch_i   (cpu_i.fetch),
        .exec_i    (cpu_i.exec),
        .discard_i (cpu_i.discard),
        .event_o   (evt[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // trigger and run completion

  logic seq_mode;
  logic trigger;
  logic arm_start;
  logic run_done;

  // two-stage modes need A seen before a B event counts
  assign seq_mode = (mode == `DBGTC_M_ATHENB) || (mode == `DBGTC_M_AEVB);

  always_comb
  begin
    if (seq_mode)
      trigger = seen_a && evt[1];
    else if (mode == `DBGTC_M_EVB)
      trigger = evt[1];
    else
      trigger = evt[0];
  end

  // a run begins on a write that arms with the enable on
  assign arm_start = wr_ctrl && wb_dat_i[`DBGTC_CTRL_ARM] && next_en;

  // end trace stops on trigger, begin trace stops on a full buffer
  assign run_done = run_active_o
                    && (((state == ST_PRE) && trigger && !begin_eff)
                        || ((state == ST_CAPT) && fifo_full_i));

  //////////////////////////////////////////////////////////////////////////////
  // debug_control register

  // read and write at any time; a write of arm wins over completion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= `DBGTC_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl <= wb_dat_i[7:0];
      ctrl[`DBGTC_CTRL_EN]  <= next_en;
      ctrl[`DBGTC_CTRL_ARM] <= arm_start;
    end
    else if (run_done)
      ctrl[`DBGTC_CTRL_ARM] <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger_config register

  // locked while armed; bits 4 and 5 are never stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig <= `DBGTC_TRIG_RST;
    else if (wr_trig && !arm)
      trig <= wb_dat_i[7:0] & `DBGTC_TRIG_WMASK;
  end

  //////////////////////////////////////////////////////////////////////////////
  // run sequencer

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_IDLE;
    else if (arm_start)
      state <= ST_PRE;
    else if (!run_active_o || run_done)
      state <= ST_IDLE;
    else if ((state == ST_PRE) && trigger && begin_eff)
      state <= ST_CAPT;
  end

  // first stage memory for the sequential modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i || arm_start)
      seen_a <= 1'b0;
    else if (run_active_o && seq_mode && evt[0])
      seen_a <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // trace buffer strobes

  // circular fill before the trigger, or storage after it
  assign trace_store_o = !ev_mode
                         && (((state == ST_PRE) && !begin_eff)
                             || (state == ST_CAPT));

  // each B event stores a byte once the event run is going
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      event_store_o <= 1'b0;
    else
      event_store_o <= run_active_o && ev_mode && !fifo_full_i
                       && (state != ST_IDLE) && trigger;
  end

  // one pulse so the buffer can clear its count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run_start_o <= 1'b0;
    else
      run_start_o <= arm_start;
  end

  //////////////////////////////////////////////////////////////////////////////
  // break requests to the core

  // timing follows run completion, which opcode qualification holds back in end trace until the opcode executes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brk_o <= '0;
    else
    begin
      brk_o.tag       <= run_done && brk_en && tag_sel;
      brk_o.force_brk <= run_done && brk_en && !tag_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status and bus answer

  // the flag mirrors arm while the unit is enabled
  assign run_active_o = en && arm;

  // answer one cycle after the request, drop ack the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= req && !ack;
  end

  assign wb_ack_o = ack;

  // read data captured with ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (req && !ack)
    begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        `DBGTC_OFS_CTRL: wb_dat_o[7:0] <= ctrl;
        `DBGTC_OFS_TRIG: wb_dat_o[7:0] <= trig;
        `DBGTC_OFS_STAT:
        begin
          wb_dat_o[`DBGTC_STAT_RUN]   <= run_active_o;
          wb_dat_o[`DBGTC_STAT_CAPT]  <= state == ST_CAPT;
          wb_dat_o[`DBGTC_STAT_SEENA] <= seen_a;
        end
        default:         wb_dat_o <= '0;
      endcase
    end
  end

endmodule

// ---- common/dbgtc_params.svh ----
// Functional notes
// - enable bit 7 of debug_control cannot be set while the chip is secured.
// - writing 1 to bit 6 arms a run; run end clears it automatically.
// - writing 0 to arm or enable stops a run at once.
// - bit 5 picks tag (1) or force (0) break; no effect if breaks off.
// - bit 4 lets triggers raise a break; at 0 only trace storage happens.
// - end trace with breaks on: break when the trigger condition is met.
// - begin trace with breaks on: break when the trace buffer fills.
// - opcode qualification delays end trace breaks until the matched opcode executes.
// - with A direction qualify on, bit 3: 0 write only, 1 read only.
// - bit 2 decides whether read/write takes part in comparator A match.
// - with B direction qualify on, bit 1: 0 write only, 1 read only.
// - bit 0 decides whether read/write takes part in comparator B match.
// - debug_control is readable and writable at all times.
// - trigger_config ignores writes while armed; bits 4 and 5 read zero.
// - trigger bit 7 routes matches through opcode tracking; fire only on execute.
// - trigger bit 6: 0 circular fill until trigger, 1 trigger starts storage.
// - event-only modes ignore bit 6 and always run as begin trace.
// - modes 0000 A only, 0001 A or B, 0010 A then B.
// - 0011 store on each B event; 0100 after A, store each B event.
// - 0101 A address with B data match; 0110 A with B data mismatch.
// - 0111 fires inside A..B inclusive; 1000 below A or above B.
// - only nine modes; codes 1001 to 1111 never trigger.
// - run ends when buffer fills (begin) or on trigger (end trace).
// - while enabled, run_active_flag reads as a copy of the arm bit.
`ifndef DBGTC_PARAMS_SVH
`define DBGTC_PARAMS_SVH

// register word offsets on the bus
`define DBGTC_OFS_CTRL      4'h0
`define DBGTC_OFS_TRIG      4'h4
`define DBGTC_OFS_STAT      4'h8

// debug_control bit positions
`define DBGTC_CTRL_EN       7
`define DBGTC_CTRL_ARM      6
`define DBGTC_CTRL_TAG      5
`define DBGTC_CTRL_BRK      4
`define DBGTC_CTRL_RWA      3
`define DBGTC_CTRL_CMP_A_DIR_QUALIFY    2
`define DBGTC_CTRL_RWB      1
`define DBGTC_CTRL_CMP_B_DIR_QUALIFY    0

// trigger_config bit positions and writable mask
`define DBGTC_TRIG_OPQ      7
`define DBGTC_TRIG_BEGIN    6
`define DBGTC_TRIG_WMASK    8'hcf

// status bit positions
`define DBGTC_STAT_RUN      0
`define DBGTC_STAT_CAPT     1
`define DBGTC_STAT_SEENA    2

// reset values
`define DBGTC_CTRL_RST      8'h00
`define DBGTC_TRIG_RST      8'h00

// trigger mode codes
`define DBGTC_M_A           4'h0
`define DBGTC_M_AORB        4'h1
`define DBGTC_M_ATHENB      4'h2
`define DBGTC_M_EVB         4'h3
`define DBGTC_M_AEVB        4'h4
`define DBGTC_M_ADATB       4'h5
`define DBGTC_M_ANDATB      4'h6
`define DBGTC_M_IN          4'h7
`define DBGTC_M_OUT         4'h8

`endif

// ---- common/dbgtc_pkg.sv ----
package dbgtc_pkg;

  // run sequencing states
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_CAPT} dbgtc_state_t;

  // one watched cpu bus cycle
  typedef struct packed {
    logic [15:0] addr;     // bus address
    logic [7:0]  data;     // bus data
    logic        rw;       // 1 read, 0 write
    logic        valid;    // a bus cycle happens now
    logic        fetch;    // this cycle is an opcode fetch
    logic        exec;     // the last fetched opcode executes now
    logic        discard;  // the last fetched opcode is dropped
  } dbgtc_cpu_t;

  // break request towards the core
  typedef struct packed {
    logic tag;
    logic force_brk;
  } dbgtc_brk_t;

endpackage

// ---- src/dbgtc_qual.sv ----
`include "dbgtc_params.svh"

module dbgtc_qual
  import dbgtc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic qual_en_i,
  input  wire logic clear_i,
  // condition and opcode tracking
  input  wire logic cond_i,
  input  wire logic fetch_i,
  input  wire logic exec_i,
  input  wire logic discard_i,
  // qualified event
  output logic      event_o
);

  logic pend;

  // remember a match on a fetch until the opcode executes or is dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      pend <= 1'b0;
    else if (cond_i && fetch_i)
      pend <= 1'b1;  // new match wins over retire
    else if (exec_i || discard_i)
      pend <= 1'b0;
  end

  // pass the match straight or only when its opcode executes
  assign event_o = qual_en_i ? (pend && exec_i) : cond_i;

endmodule

// ---- verif/dbgtc_assertions.sv ----
`include "dbgtc_params.svh"

module dbgtc_checker
  import dbgtc_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // chip state, core and status
  input wire logic        secure_i,
  input wire dbgtc_brk_t  brk_o,
  input wire logic        run_active_o,
  // trace buffer strobes
  input wire logic        trace_store_o,
  input wire logic        event_store_o,
  input wire logic        run_start_o
);
  ////////////////////////////////////////
  // a write to debug_control taken at this edge
  logic wr_ctl;
  assign wr_ctl = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0]
                  & (wb_adr_i == `DBGTC_OFS_CTRL);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_secure_no_enable: assert property (wr_ctl && secure_i |=> !run_active_o)
    else $error("run armed while secured");
  a_stop_ends_run: assert property (wr_ctl && wb_dat_i[7:6] != 2'b11 |=> !run_active_o)
    else $error("run not stopped by write");
  a_arm_starts_run: assert property (wr_ctl && !secure_i && wb_dat_i[7:6] == 2'b11
                                     |=> run_active_o)
    else $error("arming write did not start run");
  a_brk_one_pulse: assert property (brk_o != 2'b00 |-> brk_o != 2'b11 ##1 brk_o == 2'b00)
    else $error("break not a single one-type pulse");
  a_brk_ends_run: assert property (brk_o != 2'b00 && !$past(wr_ctl)
                                   |-> !run_active_o && $past(run_active_o))
    else $error("break without a completed run");
  a_start_after_arm: assert property (wr_ctl && !secure_i && wb_dat_i[7:6] == 2'b11
                                      |=> run_start_o)
    else $error("no start pulse after arming write");
  a_no_store_idle: assert property (!run_active_o && !$past(run_active_o)
                                    |-> !trace_store_o)
    else $error("trace store while not armed");
  a_event_needs_run: assert property (event_store_o |-> $past(run_active_o))
    else $error("event store outside a run");
endmodule

bind dbgtc_top dbgtc_checker i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .secure_i(secure_i), .brk_o(brk_o),
  .run_active_o(run_active_o), .trace_store_o(trace_store_o),
  .event_store_o(event_store_o), .run_start_o(run_start_o)
);

// ---- verif/dbgtc_core_model.sv ----
module dbgtc_core_model
  import dbgtc_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // cycle to issue and record clear
  input  wire logic        req_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rw_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        clr_i,
  // break requests and bus activity
  input  wire dbgtc_brk_t  brk_i,
  output dbgtc_cpu_t       cpu_o,
  output logic [1:0]       seen_o
);
  initial cpu_o = '0;
  initial seen_o = 2'b00;
  // one plain access on request, else idle bus whose lines keep moving
  always @(posedge clk_i)
  begin
    if (req_i)
      cpu_o <= {addr_i, data_i, rw_i, 4'b1000};
    else
      cpu_o <= {~cpu_o.addr, ~cpu_o.data, ~cpu_o.rw, 4'b0000};
  end
  // sticky record of break pulses
  always @(posedge clk_i)
    seen_o <= clr_i ? 2'b00 : (seen_o | brk_i);
endmodule

// ---- verif/dbgtc_top_tb.sv ----
module dbgtc_top_tb
  import dbgtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sec = 1'b0, full = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h1;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, act, req = 1'b0, rrw = 1'b0, clr = 1'b1;
  logic [15:0] ca = 16'h0, cb = 16'h0, raddr = 16'h0;
  logic [7:0]  rd8 = 8'h0, v;
  logic [1:0]  seen;
  dbgtc_cpu_t  cpu;
  dbgtc_brk_t  brk;
  int          error_cnt = 0, compares = 0;

  always #5 clk_i = ~clk_i;

  dbgtc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .secure_i(sec), .cpu_i(cpu), .cmp_a_i(ca), .cmp_b_i(cb),
    .fifo_full_i(full), .trace_store_o(), .event_store_o(), .run_start_o(),
    .brk_o(brk), .run_active_o(act));

  dbgtc_core_model i_core (.clk_i(clk_i), .req_i(req), .addr_i(raddr), .rw_i(rrw),
    .data_i(rd8), .clr_i(clr), .brk_i(brk), .cpu_o(cpu), .seen_o(seen));

  ////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {3'($urandom), 1'b1};
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      error_cnt++;
      summarize();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask

  // break type expected from the control byte
  function automatic logic [1:0] exp_brk(input logic [7:0] c, input logic hit);
    return (hit && c[4]) ? {c[5], !c[5]} : 2'b00;
  endfunction

  // arm a run, issue one access, optionally fill the buffer, check outcome
  task automatic run(input logic [7:0] t, input logic [7:0] c, input logic [15:0] a,
                     input logic w, input logic [7:0] d, input logic f, input logic hit);
    wr(4'h0, 8'h00);
    wr(4'h4, t);
    wr(4'h0, c);
    clr <= 1'b0;
    req <= 1'b1;
    raddr <= a;
    rrw <= w;
    rd8 <= d;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (3) @(posedge clk_i);
    full <= f;
    repeat (2) @(posedge clk_i);
    full <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({6'h0, seen}, {6'h0, exp_brk(c, hit)});
    chk({7'h0, act}, {7'h0, !hit});
    clr <= 1'b1;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end

  initial
  begin
    void'($urandom(44));
    ca = 16'h0400 + 16'($urandom_range(16'h3000));
    cb = ca + 16'h0080;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(4'h0, 8'h00);
    rdc(4'h4, 8'h00);
    v = 8'($urandom) & 8'h3f;
    wr(4'h0, v);
    rdc(4'h0, v);
    v = 8'($urandom);
    wr(4'h4, v);
    rdc(4'h4, v & 8'hcf);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'hc0);
    wr(4'h4, 8'h4f);
    rdc(4'h4, 8'h00);
    rdc(4'h0, 8'hc0);
    rdc(4'h8, 8'h01);
    wr(4'h0, 8'h80);
    rdc(4'h8, 8'h00);
    wr(4'hc, 8'hff);
    rdc(4'hc, 8'h00);
    sec <= 1'b1;
    wr(4'h0, 8'hc0);
    rdc(4'h0, 8'h00);
    sec <= 1'b0;
    run(8'h00, 8'hf0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b1);
    run(8'h00, 8'hd0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b1);
    run(8'h00, 8'hc0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b1);
    run(8'h00, 8'hd4, ca, 1'b1, 8'($urandom), 1'b0, 1'b0);
    run(8'h00, 8'hd4, ca, 1'b0, 8'($urandom), 1'b0, 1'b1);
    run(8'h00, 8'hd8, ca, 1'b0, 8'($urandom), 1'b0, 1'b1);
    run(8'h01, 8'hd1, cb, 1'b1, 8'($urandom), 1'b0, 1'b0);
    run(8'h01, 8'hd3, cb, 1'b1, 8'($urandom), 1'b0, 1'b1);
    run(8'h02, 8'hd0, cb, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    run(8'h07, 8'hd0, ca + 16'h1, 1'($urandom), 8'($urandom), 1'b0, 1'b1);
    run(8'h08, 8'hd0, ca + 16'h1, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    run(8'h08, 8'hd0, cb + 16'h1, 1'($urandom), 8'($urandom), 1'b0, 1'b1);
    run(8'h05, 8'hd0, ca, 1'($urandom), cb[7:0], 1'b0, 1'b1);
    run(8'h05, 8'hd0, ca, 1'($urandom), ~cb[7:0], 1'b0, 1'b0);
    run(8'h06, 8'hd0, ca, 1'($urandom), cb[7:0], 1'b0, 1'b0);
    run(8'h06, 8'hd0, ca, 1'($urandom), ~cb[7:0], 1'b0, 1'b1);
    run(8'h40, 8'hd0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    run(8'h40, 8'hf0, ca, 1'($urandom), 8'($urandom), 1'b1, 1'b1);
    run(8'h03, 8'hd0, cb, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    run(8'h04, 8'hd0, cb, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    run(8'h80, 8'hd0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    for (int m = 9; m < 16; m++)
      run(8'(m), 8'hd0, ca, 1'($urandom), 8'($urandom), 1'b0, 1'b0);
    summarize();
  end
endmodule
